// ==== hw/tcdc_regs.svh ====
`ifndef TCDC_REGS_SVH
`define TCDC_REGS_SVH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses).
// ----------------------------------------------------------------------------
`define TCDC_CH0_CONTROL_ADDR   32'hffff8000
`define TCDC_CH0_BASE_MASK_ADDR 32'hffff8004
`define TCDC_CH0_WAIT_ADDR      32'hffff8008
`define TCDC_CH1_CONTROL_ADDR   32'hffff8100
`define TCDC_CH1_BASE_MASK_ADDR 32'hffff8104
`define TCDC_CH1_WAIT_ADDR      32'hffff8108
`define TCDC_REFRESH_ADDR       32'hffff8800
`define TCDC_STATUS_ADDR        32'hffff8804
// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define TCDC_BASE_HI        31
`define TCDC_BASE_LO        20
`define TCDC_ROW_HI         18
`define TCDC_ROW_LO         16
`define TCDC_COL_HI         14
`define TCDC_COL_LO         12
`define TCDC_PRECHARGE_BIT  11
`define TCDC_SIZE_HI        5
`define TCDC_SIZE_LO        3
`define TCDC_NARROW_BIT     2
`define TCDC_RESERVED_BIT   1
`define TCDC_PAGE_STYLE_BIT 0
`define TCDC_EXT_BURST_LO   20
`define TCDC_EXT_SINGLE_LO  16
`define TCDC_DMA_BURST_LO   12
`define TCDC_DMA_SINGLE_LO  8
`define TCDC_CPU_BURST_LO   4
`define TCDC_CPU_SINGLE_LO  0
`define TCDC_SELF_REF_BIT   15
`define TCDC_INTERVAL_HI    9
`define TCDC_INTERVAL_LO    0
// ----------------------------------------------------------------------------
// Reset values and timing counts.
// ----------------------------------------------------------------------------
`define TCDC_CONTROL_RESET   32'h00000000
`define TCDC_BASE_MASK_RESET 32'h00000000
`define TCDC_WAIT_RESET      32'h00000000
`define TCDC_INTERVAL_RESET  10'h180
`define TCDC_PRECHARGE_LONG  3'h3
`define TCDC_PRECHARGE_SHORT 3'h2
`define TCDC_CONTROL_MASK    32'hfff77ffd
`define TCDC_WAIT_MASK       32'h00777737
`define TCDC_REFRESH_MASK    32'h000083ff
`endif

// ==== hw/tcdc_pkg.sv ====
package tcdc_pkg;
   // Bus masters that may own an access.
   typedef enum logic [1:0] {
      TCDC_MASTER_CPU,
      TCDC_MASTER_DMA,
      TCDC_MASTER_EXT
   } tcdc_master_e;

   // Per-channel configuration decoded from the registers.
   typedef struct packed {
      logic [11:0] base;
      logic [11:0] mask;
      logic [2:0]  row_size;
      logic [2:0]  col_size;
      logic        precharge_short;
      logic [2:0]  total_size;
      logic        narrow_bus;
      logic        page_style;
      logic [31:0] wait_cfg;
   } tcdc_chan_cfg_s;

   // Controller sequencer states.
   typedef enum logic [2:0] {
      TCDC_IDLE,
      TCDC_ACCESS,
      TCDC_WAIT,
      TCDC_PRECHARGE,
      TCDC_REFRESH,
      TCDC_SELF_REFRESH
   } tcdc_state_e;
endpackage : tcdc_pkg

// ==== hw/tcdc_cfg_if.sv ====
`timescale 1ns/1ps
// Carries both channel configurations from the register file to the decoders.
interface tcdc_cfg_if;
   import tcdc_pkg::*;
   tcdc_chan_cfg_s ch0;
   tcdc_chan_cfg_s ch1;
   logic [9:0]     interval;
   logic           self_ref_en;
   modport regs (output ch0, output ch1, output interval, output self_ref_en);
   modport user (input ch0, input ch1, input interval, input self_ref_en);
endinterface : tcdc_cfg_if

// ==== hw/tcdc_chan_sel.sv ====
`timescale 1ns/1ps
`include "tcdc_regs.svh"
// Chooses the channel and bank for a physical address.
module tcdc_chan_sel
   import tcdc_pkg::*;
(
   tcdc_cfg_if.user         cfg,
   input  wire logic [31:0] i_addr,
   output logic             o_hit,
   output logic             o_chan,
   output logic [1:0]       o_bank
);
   logic [1:0] hit;
   logic [1:0] bank [2];
   // Bits below the channel size are not compared with the base.
   function automatic logic [11:0] size_mask(input logic [2:0] sz);
      size_mask = 12'hfff << sz;
   endfunction : size_mask

   // Per-channel masked compare and bank pick.
   for (genvar c = 0; c < 2; c++) begin : g_chan
      tcdc_chan_cfg_s cc;
      logic [11:0]    keep;
      assign cc = (c == 0) ? cfg.ch0 : cfg.ch1;
      assign keep = ~cc.mask & size_mask(cc.total_size); // [R5] [R3]
      assign hit[c] = ((i_addr[31:20] ^ cc.base) & keep) == 12'h000; // [R4]
      assign bank[c] = 2'((i_addr >> (5'd18 + 5'(cc.total_size))) & 32'h3); // [R2]
   end

   // Both hit: higher base wins, equal bases give channel 0.
   always_comb begin
      o_hit  = |hit;
      o_chan = hit[1] & (~hit[0] | (cfg.ch1.base > cfg.ch0.base)); // [R22]
      o_bank = o_chan ? bank[1] : bank[0];
   end
endmodule : tcdc_chan_sel

// ==== hw/tcdc_wait_sel.sv ====
`timescale 1ns/1ps
`include "tcdc_regs.svh"
// Picks the wait count for master and access type.
module tcdc_wait_sel
   import tcdc_pkg::*;
(
   input  wire logic [31:0]  i_wait_cfg,
   input  wire tcdc_master_e i_master,
   input  wire logic         i_burst,
   output logic [2:0]        o_waits
);
   // Field chosen by master and burst.
   always_comb begin
      o_waits = 3'h0;
      unique case (i_master)
         TCDC_MASTER_EXT: o_waits = i_burst ? i_wait_cfg[`TCDC_EXT_BURST_LO +: 3]   // [R13]
                                            : i_wait_cfg[`TCDC_EXT_SINGLE_LO +: 3]; // [R14]
         TCDC_MASTER_DMA: o_waits = i_burst ? i_wait_cfg[`TCDC_DMA_BURST_LO +: 3]   // [R15]
                                            : i_wait_cfg[`TCDC_DMA_SINGLE_LO +: 3]; // [R16]
         TCDC_MASTER_CPU: o_waits = i_burst ? {1'b0, i_wait_cfg[`TCDC_CPU_BURST_LO +: 2]} // [R17]
                                            : i_wait_cfg[`TCDC_CPU_SINGLE_LO +: 3];       // [R18]
         default:         o_waits = 3'h0;
      endcase
   end
endmodule : tcdc_wait_sel

// ==== hw/tcdc_ctrl.sv ====
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "tcdc_regs.svh"
// Operation
// [R1] Two independent channels, each up to four banks with own configuration.
// [R2] Software makes each bank one quarter of the channel size.
// [R3] Channel size field bits 5:3 sets total size of four banks.
// [R4] Base field bits 31:20 compared with upper physical address bits.
// [R5] Mask bit one drops matching base bit from the comparison.
// [R6] Row size field bits 18:16 gives rows per bank.
// [R7] Column size field bits 14:12 gives column words per bank.
// [R8] Bit 11: zero three, one two precharge cycles after miss or refresh.
// [R9] Bit 2 selects 16-bit bus when one, 32-bit when zero.
// [R10] Software sets bus width after reset before relying on it.
// [R11] Software keeps reserved bit 1 at zero.
// [R12] Bit 0 selects EDO timing when one, fast page when zero.
// [R13] Wait bits 22:20: external master burst wait cycles.
// [R14] Wait bits 18:16: external master single wait cycles.
// [R15] Wait bits 14:12: DMA burst wait cycles.
// [R16] Wait bits 10:8: DMA single wait cycles.
// [R17] Wait bits 5:4: processor burst wait cycles, zero to three.
// [R18] Wait bits 2:0: processor single wait cycles.
// [R19] CAS-before-RAS refresh normally; self refresh allowed in halt mode.
// [R20] Refresh interval bits 9:0 counts clocks between refreshes.
// [R21] Refresh register bit 15 enables self refresh while halted.
// [R22] Both channels hit: higher base wins, equal bases pick channel 0.
// [R23] Wait count comes from the selected channel's master and type field.
// [R24] Software avoids reserved row, column and size encodings.
module tcdc_ctrl
   import tcdc_pkg::*;
(
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   input  wire logic [31:0]  i_reg_addr,
   input  wire logic [31:0]  i_reg_wdata,
   input  wire logic         i_reg_wr,
   input  wire logic         i_reg_rd,
   output logic [31:0]       o_reg_rdata,
   input  wire logic         i_req,
   input  wire logic [31:0]  i_req_addr,
   input  wire tcdc_master_e i_req_master,
   input  wire logic         i_req_burst,
   input  wire logic         i_halt,
   output logic              o_req_ack,
   output logic              o_req_done,
   output logic              o_ras_n,
   output logic [3:0]        o_cas_n,
   output logic [1:0]        o_bank,
   output logic              o_chan,
   output logic              o_narrow_bus,
   output logic              o_page_edo,
   output logic [2:0]        o_row_size,
   output logic [2:0]        o_col_size,
   output logic              o_refresh,
   output logic              o_self_refresh
);
   // ------------------------------------------------------------------------
   // Registers.
   // ------------------------------------------------------------------------
   logic [31:0] ch_control [2];
   logic [31:0] ch_base_mask [2];
   logic [31:0] ch_wait [2];
   logic [31:0] refresh_control;
   tcdc_state_e state;
   tcdc_state_e next_state;
   logic [9:0]  refresh_count;
   logic        refresh_due;
   logic [2:0]  wait_count;
   logic [2:0]  precharge_count;
   logic        halt_s1;
   logic        halt_s2;
   logic        cur_chan;
   logic [1:0]  cur_bank;
   logic        page_open;
   logic        sel_hit;
   logic        sel_chan;
   logic [1:0]  sel_bank;
   logic [2:0]  sel_waits;
   logic [2:0]  precharge_len;
   logic        page_miss;

   tcdc_cfg_if cfg ();

   // Whether the address is channel c's copy of a channel register.
   function automatic logic chan_hit(input logic [31:0] a, off0, off1, input int c);
      chan_hit = (a == ((c == 0) ? off0 : off1));
   endfunction : chan_hit

   // Software writes to channel registers; reserved bits stay zero.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int c = 0; c < 2; c++) begin
            ch_control[c]   <= `TCDC_CONTROL_RESET;
            ch_base_mask[c] <= `TCDC_BASE_MASK_RESET;
            ch_wait[c]      <= `TCDC_WAIT_RESET;
         end
      end else if (i_reg_wr) begin
         for (int c = 0; c < 2; c++) begin
            if (chan_hit(i_reg_addr, `TCDC_CH0_CONTROL_ADDR, `TCDC_CH1_CONTROL_ADDR, c)) begin
               ch_control[c] <= i_reg_wdata & `TCDC_CONTROL_MASK; // [R1] [R11]
            end
            if (chan_hit(i_reg_addr, `TCDC_CH0_BASE_MASK_ADDR, `TCDC_CH1_BASE_MASK_ADDR, c)) begin
               ch_base_mask[c] <= i_reg_wdata & 32'hfff00000; // [R5]
            end
            if (chan_hit(i_reg_addr, `TCDC_CH0_WAIT_ADDR, `TCDC_CH1_WAIT_ADDR, c)) begin
               ch_wait[c] <= i_reg_wdata & `TCDC_WAIT_MASK;
            end
         end
      end
   end

   // Refresh control register with its documented interval default.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         refresh_control <= {22'h000000, `TCDC_INTERVAL_RESET}; // [R20]
      end else if (i_reg_wr && i_reg_addr == `TCDC_REFRESH_ADDR) begin
         refresh_control <= i_reg_wdata & `TCDC_REFRESH_MASK;
      end
   end

   // Read data stands in the cycle after the read strobe; unmapped reads zero.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= 32'h00000000;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            `TCDC_CH0_CONTROL_ADDR:   o_reg_rdata <= ch_control[0];
            `TCDC_CH0_BASE_MASK_ADDR: o_reg_rdata <= ch_base_mask[0];
            `TCDC_CH0_WAIT_ADDR:      o_reg_rdata <= ch_wait[0];
            `TCDC_CH1_CONTROL_ADDR:   o_reg_rdata <= ch_control[1];
            `TCDC_CH1_BASE_MASK_ADDR: o_reg_rdata <= ch_base_mask[1];
            `TCDC_CH1_WAIT_ADDR:      o_reg_rdata <= ch_wait[1];
            `TCDC_REFRESH_ADDR:       o_reg_rdata <= refresh_control;
            `TCDC_STATUS_ADDR:        o_reg_rdata <= {24'h000000, page_open, cur_bank, cur_chan,
                                                      1'b0, 3'(state)};
            default:                  o_reg_rdata <= 32'h00000000;
         endcase
      end else begin
         o_reg_rdata <= 32'h00000000;
      end
   end

   // ------------------------------------------------------------------------
   // Configuration decode.
   // ------------------------------------------------------------------------
   // Split each channel's registers into named fields.
   for (genvar c = 0; c < 2; c++) begin : g_cfg
      tcdc_chan_cfg_s f;
      assign f.base            = ch_control[c][`TCDC_BASE_HI:`TCDC_BASE_LO];        // [R4]
      assign f.mask            = ch_base_mask[c][`TCDC_BASE_HI:`TCDC_BASE_LO];      // [R5]
      assign f.row_size        = ch_control[c][`TCDC_ROW_HI:`TCDC_ROW_LO];          // [R6]
      assign f.col_size        = ch_control[c][`TCDC_COL_HI:`TCDC_COL_LO];          // [R7]
      assign f.precharge_short = ch_control[c][`TCDC_PRECHARGE_BIT];                // [R8]
      assign f.total_size      = ch_control[c][`TCDC_SIZE_HI:`TCDC_SIZE_LO];        // [R3]
      assign f.narrow_bus      = ch_control[c][`TCDC_NARROW_BIT];                   // [R9]
      assign f.page_style      = ch_control[c][`TCDC_PAGE_STYLE_BIT];               // [R12]
      assign f.wait_cfg        = ch_wait[c];
   end
   assign cfg.ch0         = g_cfg[0].f;
   assign cfg.ch1         = g_cfg[1].f;
   assign cfg.interval    = refresh_control[`TCDC_INTERVAL_HI:`TCDC_INTERVAL_LO];
   assign cfg.self_ref_en = refresh_control[`TCDC_SELF_REF_BIT];

   tcdc_chan_sel u_chan_sel (
      .cfg    (cfg),
      .i_addr (i_req_addr),
      .o_hit  (sel_hit),
      .o_chan (sel_chan),
      .o_bank (sel_bank)
   );

   tcdc_wait_sel u_wait_sel (
      .i_wait_cfg (sel_chan ? cfg.ch1.wait_cfg : cfg.ch0.wait_cfg), // [R23]
      .i_master   (i_req_master),
      .i_burst    (i_req_burst),
      .o_waits    (sel_waits)
   );

   // Channel-specific precharge length and page-miss test.
   always_comb begin
      precharge_len = (cur_chan ? cfg.ch1.precharge_short : cfg.ch0.precharge_short)
                      ? `TCDC_PRECHARGE_SHORT : `TCDC_PRECHARGE_LONG; // [R8]
      page_miss = page_open && (sel_chan != cur_chan || sel_bank != cur_bank || !i_req_burst);
   end

   // ------------------------------------------------------------------------
   // Refresh timer and halt synchroniser.
   // ------------------------------------------------------------------------
   // Halt is a pin-side level and passes two flip-flops.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         halt_s1 <= 1'b0;
         halt_s2 <= 1'b0;
      end else begin
         halt_s1 <= i_halt;
         halt_s2 <= halt_s1;
      end
   end

   // Counts system clocks; a due refresh is held until serviced, set wins.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         refresh_count <= 10'h000;
         refresh_due   <= 1'b0;
      end else begin
         if (refresh_count >= cfg.interval) begin
            refresh_count <= 10'h000; // [R20]
            refresh_due   <= 1'b1;
         end else begin
            refresh_count <= refresh_count + 10'h001;
            if (state == TCDC_REFRESH) begin
               refresh_due <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------------------
   // Access sequencer.
   // ------------------------------------------------------------------------
   // Next-state choice: self refresh, refresh, access, precharge.
   always_comb begin
      next_state = state;
      unique case (state)
         TCDC_IDLE: begin
            if (halt_s2 && cfg.self_ref_en) begin
               next_state = TCDC_SELF_REFRESH; // [R19] [R21]
            end else if (refresh_due) begin
               next_state = TCDC_REFRESH; // [R19]
            end else if (i_req && sel_hit) begin
               next_state = page_miss ? TCDC_PRECHARGE : TCDC_ACCESS;
            end
         end
         TCDC_ACCESS:       next_state = (sel_waits == 3'h0) ? TCDC_IDLE : TCDC_WAIT;
         TCDC_WAIT:         next_state = (wait_count == 3'h1) ? TCDC_IDLE : TCDC_WAIT;
         TCDC_PRECHARGE:    next_state = (precharge_count == 3'h1) ? TCDC_IDLE : TCDC_PRECHARGE;
         TCDC_REFRESH:      next_state = TCDC_PRECHARGE; // [R8]
         TCDC_SELF_REFRESH: next_state = (halt_s2 && cfg.self_ref_en) ? TCDC_SELF_REFRESH : TCDC_PRECHARGE;
         default:           next_state = TCDC_IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= TCDC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Wait and precharge counters load on entry and count down.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         wait_count      <= 3'h0;
         precharge_count <= 3'h0;
      end else begin
         if (state == TCDC_ACCESS) begin
            wait_count <= sel_waits; // [R23]
         end else if (state == TCDC_WAIT) begin
            wait_count <= wait_count - 3'h1;
         end
         if (next_state == TCDC_PRECHARGE && state != TCDC_PRECHARGE) begin
            precharge_count <= precharge_len; // [R8]
         end else if (state == TCDC_PRECHARGE) begin
            precharge_count <= precharge_count - 3'h1;
         end
      end
   end

   // Tracks the open page; refresh and precharge close it.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cur_chan  <= 1'b0;
         cur_bank  <= 2'h0;
         page_open <= 1'b0;
      end else if (state == TCDC_IDLE && next_state == TCDC_ACCESS) begin
         cur_chan  <= sel_chan;
         cur_bank  <= sel_bank;
         page_open <= i_req_burst;
      end else if (state == TCDC_PRECHARGE || state == TCDC_REFRESH) begin
         page_open <= 1'b0;
      end
   end

   // Memory control strobes, registered from the next state.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ras_n        <= 1'b1;
         o_cas_n        <= 4'hf;
         o_refresh      <= 1'b0;
         o_self_refresh <= 1'b0;
      end else begin
         o_ras_n        <= !(next_state inside {TCDC_ACCESS, TCDC_WAIT, TCDC_REFRESH, TCDC_SELF_REFRESH});
         o_cas_n        <= (next_state inside {TCDC_ACCESS, TCDC_WAIT, TCDC_REFRESH, TCDC_SELF_REFRESH})
                           ? 4'h0 : 4'hf;
         o_refresh      <= next_state == TCDC_REFRESH;
         o_self_refresh <= next_state == TCDC_SELF_REFRESH;
      end
   end

   // Access geometry of the channel in use.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_bank       <= 2'h0;
         o_chan       <= 1'b0;
         o_narrow_bus <= 1'b0;
         o_page_edo   <= 1'b0;
         o_row_size   <= 3'h0;
         o_col_size   <= 3'h0;
      end else if (state == TCDC_IDLE && next_state == TCDC_ACCESS) begin
         o_bank       <= sel_bank;
         o_chan       <= sel_chan;
         o_narrow_bus <= sel_chan ? cfg.ch1.narrow_bus : cfg.ch0.narrow_bus; // [R9]
         o_page_edo   <= sel_chan ? cfg.ch1.page_style : cfg.ch0.page_style; // [R12]
         o_row_size   <= sel_chan ? cfg.ch1.row_size : cfg.ch0.row_size;     // [R6]
         o_col_size   <= sel_chan ? cfg.ch1.col_size : cfg.ch0.col_size;     // [R7]
      end
   end

   // Handshake: ack when the access starts, done when its waits end.
   assign o_req_ack  = (state == TCDC_IDLE) && (next_state == TCDC_ACCESS);
   assign o_req_done = (state == TCDC_ACCESS && sel_waits == 3'h0) || (state == TCDC_WAIT && wait_count == 3'h1);
endmodule : tcdc_ctrl

// ==== sim/tcdc_dram_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// DRAM bank model: watches the strobes and counts row openings.
// ----------------------------------------------------------------
module tcdc_dram_model (
   input  wire logic       i_sys_clk,
   input  wire logic       i_ras_n,
   input  wire logic [3:0] i_cas_n,
   output int              o_row_opens
);
   logic ras_q = 1'b1;
   int   opens = 0;
   // A falling RAS with all CAS lanes low starts an access or a refresh.
   always_ff @(posedge i_sys_clk) begin
      ras_q <= i_ras_n;
      if (ras_q && !i_ras_n && i_cas_n == 4'h0) begin
         opens <= opens + 1;
      end
   end
   assign o_row_opens = opens;
endmodule : tcdc_dram_model

// ==== sim/tcdc_ctrl_props.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the controller top.
// ----------------------------------------------------------------
module tcdc_ctrl_props (
   input wire logic        i_sys_clk,
   input wire logic        i_rst,
   input wire logic        i_reg_rd,
   input wire logic [31:0] o_reg_rdata,
   input wire logic        i_req,
   input wire logic        o_req_ack,
   input wire logic        o_req_done,
   input wire logic        o_ras_n,
   input wire logic [3:0]  o_cas_n,
   input wire logic [1:0]  o_bank,
   input wire logic        o_chan,
   input wire logic        o_refresh,
   input wire logic        o_self_refresh
);
   // All checks run on the system clock and sleep in reset.
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   chk_done_in_time: assert property (o_req_ack |=> ##[0:7] o_req_done)
      else $error("Access done too late.");
   chk_no_reack: assert property (o_req_ack |=> !o_req_ack)
      else $error("Second ack before done.");
   chk_ack_has_req: assert property (o_req_ack |-> i_req)
      else $error("Ack without request.");
   chk_refresh_pulse: assert property (o_refresh |=> !o_refresh)
      else $error("Refresh pulse too long.");
   chk_selfref_no_ack: assert property (o_self_refresh |-> !o_req_ack)
      else $error("Ack in self refresh.");
   chk_cas_together: assert property (o_cas_n == 4'h0 || o_cas_n == 4'hf)
      else $error("CAS lanes split.");
   chk_rdata_quiet: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
      else $error("Read data without read.");
   chk_done_ras_low: assert property (o_req_done |-> !o_ras_n)
      else $error("Done with RAS high.");
   chk_row_attr_hold: assert property (!o_ras_n && !$past(o_ras_n) |-> $stable(o_chan) && $stable(o_bank))
      else $error("Channel or bank moved in open row.");
   cover property (o_req_done);
   cover property (o_refresh);
   cover property (o_self_refresh);
endmodule : tcdc_ctrl_props

bind tcdc_ctrl tcdc_ctrl_props u_props (.i_sys_clk, .i_rst, .i_reg_rd, .o_reg_rdata, .i_req, .o_req_ack,
   .o_req_done, .o_ras_n, .o_cas_n, .o_bank, .o_chan, .o_refresh, .o_self_refresh);

// ==== sim/tb_two_channel_dram_controller.sv ====
`timescale 1ns/1ps
module tb_two_channel_dram_controller;
   import tcdc_pkg::*;
   logic         i_sys_clk, i_rst, i_reg_wr, i_reg_rd, i_req, i_req_burst, i_halt;
   logic [31:0]  i_reg_addr, i_reg_wdata, i_req_addr, o_reg_rdata;
   tcdc_master_e i_req_master;
   logic         o_req_ack, o_req_done, o_ras_n, o_chan, o_narrow_bus, o_page_edo, o_refresh, o_self_refresh;
   logic [3:0]   o_cas_n;
   logic [1:0]   o_bank;
   logic [2:0]   o_row_size, o_col_size;
   int           n_mismatch, checked, rows, k, na, ch, bk, dp[2];
   logic [31:0]  mdl[7];
   logic [31:0]  adr[7] = '{32'hffff8000, 32'hffff8004, 32'hffff8008, 32'hffff8100, 32'hffff8104,
                          32'hffff8108, 32'hffff8800};
   logic [31:0]  msk[7] = '{32'hfff77ffd, 32'hfff00000, 32'h00777737, 32'hfff77ffd, 32'hfff00000,
                          32'h00777737, 32'h000083ff};
   logic [31:0]  acc_adr[3] = '{32'h01040000, 32'h002c0000, 32'h0f000000};

   tcdc_ctrl dut (.i_sys_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_req,
      .i_req_addr, .i_req_master, .i_req_burst, .i_halt, .o_req_ack, .o_req_done, .o_ras_n, .o_cas_n, .o_bank,
      .o_chan, .o_narrow_bus, .o_page_edo, .o_row_size, .o_col_size, .o_refresh, .o_self_refresh);
   tcdc_dram_model u_dram (.i_sys_clk, .i_ras_n(o_ras_n), .i_cas_n(o_cas_n), .o_row_opens(rows));

   // Free-running 250 MHz clock.
   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end

   // ----------------------------------------------------------------
   // Bench tasks.
   // ----------------------------------------------------------------
   task automatic print_verdict();
      if (n_mismatch == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic await(ref logic s, input logic v, input int lim, output int n);
      n = 1;
      @(negedge i_sys_clk);
      while (s !== v) begin
         if (n == lim) begin
            n_mismatch++;
            print_verdict();
         end
         n++;
         @(negedge i_sys_clk);
      end
   endtask : await
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      i_reg_wr    <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b0;
      @(posedge i_sys_clk);
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      i_reg_addr <= a;
      i_reg_rd   <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b0;
      @(negedge i_sys_clk);
      chk(o_reg_rdata, exp);
      @(posedge i_sys_clk);
   endtask : rd
   // The model picks channel, bank and wait count from its register image.
   task automatic acc(input logic [31:0] a, input int m, input logic b);
      logic [11:0] cm[2];
      logic        hit[2];
      int          lo;
      for (int c = 0; c < 2; c++) begin
         cm[c]  = (12'hfff << mdl[3*c][5:3]) & ~mdl[3*c+1][31:20];
         hit[c] = ((a[31:20] ^ mdl[3*c][31:20]) & cm[c]) == 12'h0;
      end
      ch = (hit[1] && (!hit[0] || mdl[3][31:20] > mdl[0][31:20])) ? 1 : 0;
      bk = (a >> (18 + mdl[3*ch][5:3])) & 3;
      lo = 8 * m + 4 * b;
      i_req        <= 1'b1;
      i_req_addr   <= a;
      i_req_master <= tcdc_master_e'(m);
      i_req_burst  <= b;
      await(o_req_ack, 1'b1, 60, na);
      @(posedge i_sys_clk);
      i_req <= 1'b0;
      await(o_req_done, 1'b1, 20, k);
      chk(k, 1 + ((mdl[3*ch+2] >> lo) & (lo == 4 ? 3 : 7)));
      chk(o_chan, ch);
      chk(o_bank, bk);
      chk(o_narrow_bus, mdl[3*ch][2]);
      chk(o_page_edo, mdl[3*ch][0]);
      chk(o_row_size, mdl[3*ch][18:16]);
      chk(o_col_size, mdl[3*ch][14:12]);
      @(posedge i_sys_clk);
   endtask : acc

   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial begin
      {i_reg_wr, i_reg_rd, i_req, i_req_burst, i_halt} = '0;
      {i_reg_addr, i_reg_wdata, i_req_addr} = '0;
      i_req_master = TCDC_MASTER_CPU;
      i_rst = 1'b1;
      void'($urandom(32'h3676));
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      for (int i = 0; i < 7; i++) rd(adr[i], i == 6 ? 32'h180 : 32'h0);
      rd(32'hffff8010, 32'h0);
      for (int i = 0; i < 7; i++) begin
         mdl[i] = $urandom & ~32'h2;
         wr(adr[i], mdl[i]);
         rd(adr[i], mdl[i] & msk[i]);
      end
      mdl = '{32'h0, 32'h0ff00000, 32'h0, 32'h01000000, 32'h0, 32'h0, 32'h180};
      for (int i = 0; i < 7; i++) begin
         if (i % 3 == 0) mdl[i] |= $urandom & 32'h00033805;
         if (i % 3 == 2) mdl[i] = $urandom & msk[i];
         wr(adr[i], mdl[i]);
      end
      for (int m = 0; m < 3; m++)
         for (int b = 0; b < 2; b++)
            for (int j = 0; j < 3; j++) acc(acc_adr[j], m, b[0]);
      i_req      <= 1'b1;
      i_req_addr <= 32'h80000000;
      repeat (20) begin
         @(negedge i_sys_clk);
         chk(o_req_ack, 1'b0);
      end
      @(posedge i_sys_clk) i_req <= 1'b0;
      mdl[6] = 32'd20;
      wr(adr[6], mdl[6]);
      for (int p = 0; p < 2; p++) begin
         mdl[0][11] = p[0];
         wr(adr[0], mdl[0]);
         acc(acc_adr[1], 0, 1'b0);
         await(o_refresh, 1'b1, 60, k);
         @(posedge i_sys_clk);
         acc(acc_adr[1], 0, 1'b0);
         dp[p] = na;
      end
      chk(dp[0] - dp[1], 1);
      await(o_refresh, 1'b1, 60, k);
      @(posedge i_sys_clk);
      await(o_refresh, 1'b1, 60, k);
      chk(k, 21);
      chk(rows > 0, 1'b1);
      @(posedge i_sys_clk) i_halt <= 1'b1;
      repeat (30) begin
         @(negedge i_sys_clk);
         chk(o_self_refresh, 1'b0);
      end
      @(posedge i_sys_clk) wr(adr[6], 32'h8014);
      await(o_self_refresh, 1'b1, 60, k);
      @(posedge i_sys_clk) i_halt <= 1'b0;
      await(o_self_refresh, 1'b0, 60, k);
      @(posedge i_sys_clk);
      acc(acc_adr[0], 2, 1'b1);
      print_verdict();
   end
endmodule : tb_two_channel_dram_controller
